// [verilog/cec_top.sv]
// APB comparator event control top with three channels and interrupt
`timescale 1ns/10ps
module cec_top
    import cec_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        device_idle,
    input  wire logic [2:0]  raw_compare,
    output logic      [2:0]  result_pin,
    output logic      [2:0]  pin_output_enable,
    output logic      [2:0]  comparator_on,
    output logic      [2:0]  low_power_select,
    output logic      [2:0]  noninv_input_select,
    output logic      [5:0]  neg_input_select,
    output logic      [2:0]  trigger,
    output logic             irq
);
    typedef struct packed {
        logic        idle_stop;
        logic [15:0] ctrl1;
        logic [15:0] ctrl2;
        logic [15:0] ctrl3;
        logic [2:0]  irq_status;
        logic [2:0]  irq_mask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  pin;
        logic [2:0]  oe;
        logic [2:0]  on;
        logic [2:0]  lp;
        logic [2:0]  ni;
        logic [5:0]  neg;
        logic [2:0]  trig;
        logic        irq;
    } cec_top_state_t;

    cec_top_state_t state;
    cec_top_state_t next_state;

    logic [2:0]  sync_cmp;
    logic [2:0]  result;
    logic [2:0]  flag;
    logic [2:0]  pulse;
    logic [2:0]  run;
    logic [2:0]  flag_write;
    logic [2:0]  flag_wdata;
    logic [15:0] ctrl [CEC_NCHAN];
    logic        access;
    logic        wr;

    function automatic logic [15:0] cec_ctrl_read(input logic [15:0] c, input logic res,
                                                  input logic flg);
        logic [15:0] v;
        v = c & CEC_CT_WMASK;
        v[CEC_CT_EVENT]  = flg;
        v[CEC_CT_RESULT] = res;
        return v;
    endfunction

    assign ctrl[0] = state.ctrl1;
    assign ctrl[1] = state.ctrl2;
    assign ctrl[2] = state.ctrl3;
    assign access  = psel & penable & ~state.pready;
    assign wr      = access & pwrite;

    // Comparator inputs are analog-side and asynchronous
    cec_sync #(
        .WIDTH (3)
    ) u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .async_in (raw_compare),
        .sync_out (sync_cmp)
    );

    for (genvar i = 0; i < CEC_NCHAN; i++) begin : g_chan
        assign run[i] = ctrl[i][CEC_CT_ENABLE] & ~(state.idle_stop & device_idle);
        assign flag_write[i] = wr & (paddr == CEC_ADDR_CTRL1 + 12'(4 * i));
        assign flag_wdata[i] = pwdata[CEC_CT_EVENT];
        cec_channel u_chan (
            .pclk        (pclk),
            .presetn     (presetn),
            .run         (run[i]),
            .raw_compare (sync_cmp[i]),
            .invert      (ctrl[i][CEC_CT_INVERT]),
            .edge_select (ctrl[i][CEC_CT_EDGE_LSB +: 2]),
            .flag_write  (flag_write[i]),
            .flag_wdata  (flag_wdata[i]),
            .result      (result[i]),
            .event_flag  (flag[i]),
            .event_pulse (pulse[i])
        );
    end

    always_comb begin
        next_state         = state;
        next_state.pready  = access;
        next_state.pslverr = 1'b0;
        next_state.prdata  = '0;
        if (access) begin
            unique case (paddr)
                CEC_ADDR_STATUS: begin
                    next_state.prdata[CEC_ST_IDLE_STOP] = state.idle_stop;
                    next_state.prdata[CEC_ST_EVT_LSB +: 3] = flag;
                    next_state.prdata[CEC_ST_OUT_LSB +: 3] = result;
                    if (pwrite) begin
                        next_state.idle_stop = pwdata[CEC_ST_IDLE_STOP];
                    end
                end
                CEC_ADDR_CTRL1: begin
                    next_state.prdata[15:0] = cec_ctrl_read(state.ctrl1, result[0], flag[0]);
                    if (pwrite) next_state.ctrl1 = pwdata[15:0] & CEC_CT_WMASK;
                end
                CEC_ADDR_CTRL2: begin
                    next_state.prdata[15:0] = cec_ctrl_read(state.ctrl2, result[1], flag[1]);
                    if (pwrite) next_state.ctrl2 = pwdata[15:0] & CEC_CT_WMASK;
                end
                CEC_ADDR_CTRL3: begin
                    next_state.prdata[15:0] = cec_ctrl_read(state.ctrl3, result[2], flag[2]);
                    if (pwrite) next_state.ctrl3 = pwdata[15:0] & CEC_CT_WMASK;
                end
                CEC_ADDR_IRQ_ST: begin
                    next_state.prdata[2:0] = state.irq_status;
                    if (pwrite) next_state.irq_status = state.irq_status & ~pwdata[2:0];
                end
                CEC_ADDR_IRQ_MSK: begin
                    next_state.prdata[2:0] = state.irq_mask;
                    if (pwrite) next_state.irq_mask = pwdata[2:0];
                end
                default: next_state.pslverr = 1'b1;
            endcase
        end
        // Set wins over a same-cycle write-one clear
        next_state.irq_status = next_state.irq_status | pulse;
        next_state.trig = pulse;
        next_state.irq  = |(next_state.irq_status & next_state.irq_mask);
        for (int i = 0; i < CEC_NCHAN; i++) begin
            next_state.pin[i] = result[i] & ctrl[i][CEC_CT_PIN_OE];
            next_state.oe[i]  = ctrl[i][CEC_CT_PIN_OE];
            next_state.on[i]  = run[i];
            next_state.lp[i]  = ctrl[i][CEC_CT_LOW_POWER];
            next_state.ni[i]  = ctrl[i][CEC_CT_NONINV];
            next_state.neg[2*i +: 2] = ctrl[i][CEC_CT_NEG_LSB +: 2];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign prdata              = state.prdata;
    assign pready              = state.pready;
    assign pslverr             = state.pslverr;
    assign result_pin          = state.pin;
    assign pin_output_enable   = state.oe;
    assign comparator_on       = state.on;
    assign low_power_select    = state.lp;
    assign noninv_input_select = state.ni;
    assign neg_input_select    = state.neg;
    assign trigger             = state.trig;
    assign irq                 = state.irq;
endmodule

// [verilog/cec_pkg.sv]
// Package of constants for the comparator event control block
package cec_pkg;
    localparam int          CEC_NCHAN        = 3;
    localparam logic [11:0] CEC_ADDR_STATUS  = 12'h000;
    localparam logic [11:0] CEC_ADDR_CTRL1   = 12'h004;
    localparam logic [11:0] CEC_ADDR_CTRL2   = 12'h008;
    localparam logic [11:0] CEC_ADDR_CTRL3   = 12'h00C;
    localparam logic [11:0] CEC_ADDR_IRQ_ST  = 12'h010;
    localparam logic [11:0] CEC_ADDR_IRQ_MSK = 12'h014;
    // Status register fields
    localparam int          CEC_ST_IDLE_STOP = 15;
    localparam int          CEC_ST_EVT_LSB   = 8;
    localparam int          CEC_ST_OUT_LSB   = 0;
    // Control register fields
    localparam int          CEC_CT_ENABLE    = 15;
    localparam int          CEC_CT_PIN_OE    = 14;
    localparam int          CEC_CT_INVERT    = 13;
    localparam int          CEC_CT_LOW_POWER = 12;
    localparam int          CEC_CT_EVENT     = 9;
    localparam int          CEC_CT_RESULT    = 8;
    localparam int          CEC_CT_EDGE_LSB  = 6;
    localparam int          CEC_CT_NONINV    = 4;
    localparam int          CEC_CT_NEG_LSB   = 0;
    localparam logic [15:0] CEC_CT_WMASK     = 16'hF2D3;
    localparam logic [15:0] CEC_RESET_VALUE  = 16'h0000;
    // Edge select codes
    localparam logic [1:0]  CEC_EDGE_NONE    = 2'h0;
    localparam logic [1:0]  CEC_EDGE_RISE    = 2'h1;
    localparam logic [1:0]  CEC_EDGE_FALL    = 2'h2;
    localparam logic [1:0]  CEC_EDGE_ANY     = 2'h3;
endpackage

// [verilog/cec_sync.sv]
// Two-flop synchroniser for the raw comparator outputs
`timescale 1ns/10ps
module cec_sync
    import cec_pkg::*;
#(
    parameter int WIDTH = 3
) (
    input  wire logic             pclk,
    input  wire logic             presetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] first;
        logic [WIDTH-1:0] second;
    } cec_sync_state_t;

    cec_sync_state_t state;
    cec_sync_state_t next_state;

    always_comb begin
        next_state.first  = async_in;
        next_state.second = state.first;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign sync_out = state.second;
endmodule

// [verilog/cec_channel.sv]
// One comparator channel: polarity, edge detect and event flag
`timescale 1ns/10ps
module cec_channel
    import cec_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       run,
    input  wire logic       raw_compare,
    input  wire logic       invert,
    input  wire logic [1:0] edge_select,
    input  wire logic       flag_write,
    input  wire logic       flag_wdata,
    output logic            result,
    output logic            event_flag,
    output logic            event_pulse
);
    typedef struct packed {
        logic result;
        logic flag;
        logic pulse;
    } cec_chan_state_t;

    cec_chan_state_t state;
    cec_chan_state_t next_state;
    logic            adj;
    logic            hit;

    always_comb begin
        adj = run & (raw_compare ^ invert);
        hit = 1'b0;
        unique case (edge_select)
            CEC_EDGE_NONE: hit = 1'b0;
            CEC_EDGE_RISE: hit = adj & ~state.result;
            CEC_EDGE_FALL: hit = ~adj & state.result;
            CEC_EDGE_ANY:  hit = adj ^ state.result;
        endcase
        hit = hit & run & ~state.flag;
        next_state.result = adj;
        next_state.pulse  = hit;
        next_state.flag   = state.flag;
        if (flag_write) begin
            next_state.flag = flag_wdata;
        end
        if (hit) begin
            next_state.flag = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign result      = state.result;
    assign event_flag  = state.flag;
    assign event_pulse = state.pulse;
endmodule

// [verif/cec_top_sva.sv]
// Assertion checker for the comparator event control top
`timescale 1ns/10ps
module cec_top_sva
    import cec_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        device_idle,
    input wire logic [2:0]  comparator_on,
    input wire logic [2:0]  result_pin,
    input wire logic [2:0]  pin_output_enable,
    input wire logic [2:0]  low_power_select,
    input wire logic [2:0]  noninv_input_select,
    input wire logic [2:0]  trigger,
    input wire logic        irq
);
    logic       stop_q;
    logic [2:0] msk_q;
    logic [2:0] blk_q;
    logic       wr_done;
    assign wr_done = psel && penable && pready && pwrite;
    // Shadow copies, so event rules can be judged from the ports alone
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_q <= 1'b0;
            msk_q  <= 3'h0;
            blk_q  <= 3'h0;
        end else begin
            if (wr_done && paddr == CEC_ADDR_STATUS) stop_q <= pwdata[15];
            if (wr_done && paddr == CEC_ADDR_IRQ_MSK) msk_q <= pwdata[2:0];
            for (int i = 0; i < 3; i++) begin
                if (trigger[i]) blk_q[i] <= 1'b1;
                else if (wr_done && paddr == CEC_ADDR_CTRL1 + 12'(4 * i)) blk_q[i] <= 1'b0;
            end
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_wait: assert property ($rose(penable) |-> !pready ##1 pready)
        else $error("pready not one cycle after access start");
    a_err_unmapped: assert property (pready && paddr > CEC_ADDR_IRQ_MSK |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper read bits not zero");
    a_flag_blocks: assert property ((trigger & blk_q) == 3'h0)
        else $error("trigger while event flag set");
    a_trig_pulse: assert property (trigger[0] |=> !trigger[0])
        else $error("trigger longer than one cycle");
    a_irq_follows: assert property (|(trigger & msk_q) |-> irq)
        else $error("unmasked event without interrupt");
    a_idle_stop: assert property (device_idle && stop_q |=> comparator_on == 3'h0)
        else $error("comparator running in idle with stop set");
    a_pin_gated: assert property ((result_pin & ~pin_output_enable) == 3'h0)
        else $error("result pin driven while disabled");
    a_ctrl_fields: assert property (wr_done && paddr == CEC_ADDR_CTRL1 |=>
        low_power_select[0] == $past(pwdata[12]) && noninv_input_select[0] == $past(pwdata[4]))
        else $error("control outputs do not follow write");
    c_trig: cover property (|trigger);
    c_irq: cover property ($rose(irq));
    c_err: cover property (pslverr);
endmodule

bind cec_top cec_top_sva u_sva (
    .pclk                (pclk),
    .presetn             (presetn),
    .psel                (psel),
    .penable             (penable),
    .pwrite              (pwrite),
    .paddr               (paddr),
    .pwdata              (pwdata),
    .prdata              (prdata),
    .pready              (pready),
    .pslverr             (pslverr),
    .device_idle         (device_idle),
    .comparator_on       (comparator_on),
    .result_pin          (result_pin),
    .pin_output_enable   (pin_output_enable),
    .low_power_select    (low_power_select),
    .noninv_input_select (noninv_input_select),
    .trigger             (trigger),
    .irq                 (irq)
);

// [verif/test_cec_top.sv]
// Self-checking testbench for the comparator event control top
`timescale 1ns/10ps
module test_cec_top;
    import cec_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic        device_idle = 1'b0;
    logic [2:0]  raw_compare = 3'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  result_pin, pin_output_enable, comparator_on;
    logic [2:0]  low_power_select, noninv_input_select, trigger;
    logic [5:0]  neg_input_select;
    logic        irq;
    logic [31:0] rd;
    logic        err;
    int          errors = 0;
    int          compares = 0;
    int          ntrig = 0;

    cec_top DUT (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .device_idle         (device_idle),
        .raw_compare         (raw_compare),
        .result_pin          (result_pin),
        .pin_output_enable   (pin_output_enable),
        .comparator_on       (comparator_on),
        .low_power_select    (low_power_select),
        .noninv_input_select (noninv_input_select),
        .neg_input_select    (neg_input_select),
        .trigger             (trigger),
        .irq                 (irq)
    );

    always #50 pclk = ~pclk;
    // Counted mid-cycle, where the registered pulse is settled
    always @(negedge pclk) if (trigger[0] === 1'b1) ntrig++;

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No fixed latency assumed: the wait ends when pready is seen high, or else the watchdog ends it
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic stop_test;
        $display("Checks %0d, mismatches %0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Generous bound: the whole sequence needs well under 2000 cycles
    initial begin
        #3000000;
        errors++;
        stop_test();
    end

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 12'(4 * i), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        $display("Test reset values done");
        apb(1'b1, CEC_ADDR_STATUS, 32'hFFFF_FFFF);
        apb(1'b1, CEC_ADDR_CTRL1, 32'hFFFF_FFFF);
        apb(1'b0, CEC_ADDR_CTRL1, 32'h0);
        chk("control mask", rd, 32'h0000_F3D3);
        apb(1'b0, CEC_ADDR_STATUS, 32'h0);
        chk("status mask", rd, 32'h0000_8101);
        chk("result pin", 32'(result_pin), 32'h1);
        chk("pin enable", 32'(pin_output_enable), 32'h1);
        chk("low power", 32'(low_power_select[0]), 32'h1);
        chk("noninv select", 32'(noninv_input_select[0]), 32'h1);
        chk("neg select", 32'(neg_input_select[1:0]), 32'h3);
        apb(1'b0, 12'h018, 32'h0);
        chk("unmapped error", 32'(err), 32'h1);
        apb(1'b1, CEC_ADDR_STATUS, 32'h0);
        apb(1'b1, CEC_ADDR_CTRL1, 32'h2000);
        apb(1'b0, CEC_ADDR_STATUS, 32'h0);
        chk("disabled result", rd, 32'h0);
        $display("Test register fields done");
        // Every edge code, with the interrupt masked and unmasked
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, CEC_ADDR_IRQ_MSK, 32'(k[2]));
            apb(1'b1, CEC_ADDR_CTRL1, 32'h8000 | (32'(k[1:0]) << 6));
            ntrig = 0;
            raw_compare[0] <= 1'b1;
            repeat (8) @(posedge pclk);
            chk("rise events", 32'(ntrig), 32'(k[0]));
            raw_compare[0] <= 1'b0;
            repeat (8) @(posedge pclk);
            chk("total events", 32'(ntrig), 32'(k[1:0] != 0));
            chk("irq", 32'(irq), 32'(k[2] && k[1:0] != 0));
            apb(1'b0, CEC_ADDR_STATUS, 32'h0);
            chk("event copy", rd, 32'(k[1:0] != 0) << 8);
            apb(1'b1, CEC_ADDR_CTRL1, 32'h0);
            apb(1'b1, CEC_ADDR_IRQ_ST, 32'h7);
            apb(1'b0, CEC_ADDR_IRQ_ST, 32'h0);
            chk("irq clear", rd | 32'(irq), 32'h0);
        end
        $display("Test event edges done");
        apb(1'b1, CEC_ADDR_CTRL2, 32'hE000);
        for (int v = 0; v < 2; v++) begin
            raw_compare[1] <= v[0];
            repeat (6) @(posedge pclk);
            apb(1'b0, CEC_ADDR_STATUS, 32'h0);
            chk("inverted result", rd, 32'(!v[0]) << 1);
            chk("result pin", 32'(result_pin), 32'(!v[0]) << 1);
        end
        $display("Test polarity done");
        apb(1'b1, CEC_ADDR_CTRL3, 32'h8000);
        device_idle <= 1'b1;
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, CEC_ADDR_STATUS, 32'(s) << 15);
            repeat (2) @(posedge pclk);
            chk("idle run", 32'(comparator_on), (s == 0) ? 32'h6 : 32'h0);
        end
        $display("Test idle stop done");
        stop_test();
    end
endmodule
